// [rtl/acw_pkg.sv]
package acw_pkg;
    // Control word geometry
    localparam int          CW_WIDTH      = 14;
    localparam int          WORD_WIDTH    = 16;
    localparam int          BYTE_WIDTH    = 8;
    localparam logic [13:0] CW_RESET      = 14'h0000;
    localparam logic [13:0] CW_LIVE_MASK  = 14'h03FF;
    // Bit positions inside the control word
    localparam int POS_CAL_LAUNCH  = 0;
    localparam int POS_CAL_SEL_LO  = 1;
    localparam int POS_CAL_SEL_HI  = 2;
    localparam int POS_CAL_KIND    = 3;
    localparam int POS_CONV_LAUNCH = 4;
    localparam int POS_RANGE       = 5;
    localparam int POS_RD_SEL_LO   = 6;
    localparam int POS_RD_SEL_HI   = 7;
    localparam int POS_PM_LO       = 8;
    localparam int POS_PM_HI       = 9;
    // Word address field of the assembled 16-bit word
    localparam int          POS_ADDR_LO   = 14;
    localparam int          POS_ADDR_HI   = 15;
    localparam logic [1:0]  ADDR_NONE     = 2'h0;
    localparam logic [1:0]  ADDR_TEST     = 2'h1;
    localparam logic [1:0]  ADDR_CAL      = 2'h2;
    localparam logic [1:0]  ADDR_CTRL     = 2'h3;
    // Read selection codes
    localparam logic [1:0]  RD_RESULT     = 2'h0;
    localparam logic [1:0]  RD_TEST       = 2'h1;
    localparam logic [1:0]  RD_CAL        = 2'h2;
    localparam logic [1:0]  RD_STATUS     = 2'h3;
    // Status word fixed fields
    localparam logic [5:0]  STATUS_ZEROS  = 6'h00;
    localparam logic [1:0]  STATUS_ONES   = 2'h3;
    // Calibration selection codes
    localparam logic [1:0]  CSEL_FULL     = 2'h0;
    localparam logic [1:0]  CSEL_GAIN_OFS = 2'h1;
    localparam logic [1:0]  CSEL_OFS      = 2'h2;
    localparam logic [1:0]  CSEL_GAIN     = 2'h3;

    typedef enum logic [2:0] {
        CAL_STEP_DAC      = 3'b000,
        CAL_STEP_INT_GAIN = 3'b001,
        CAL_STEP_INT_OFS  = 3'b010,
        CAL_STEP_SYS_GAIN = 3'b011,
        CAL_STEP_SYS_OFS  = 3'b100
    } acw_cal_step_t;

    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_ISSUE = 2'b01,
        SEQ_WAIT  = 2'b10
    } acw_seq_state_t;
endpackage

// [rtl/acw_byte_pair.sv]
module acw_byte_pair
    import acw_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Byte side
    input  wire logic                  byte_stb,
    input  wire logic [BYTE_WIDTH-1:0] byte_in,
    // Word side
    output logic                       word_stb,
    output logic [WORD_WIDTH-1:0]      word
);
    logic                  high_next_r;
    logic [BYTE_WIDTH-1:0] low_r;

    // Low byte first, high byte completes the word
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            high_next_r <= 1'b0;
            low_r       <= '0;
        end
        else if (byte_stb)
        begin
            high_next_r <= ~high_next_r;
            if (!high_next_r)
                low_r <= byte_in;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            word_stb <= 1'b0;
            word     <= '0;
        end
        else
        begin
            word_stb <= byte_stb & high_next_r;
            if (byte_stb && high_next_r)
                word <= {byte_in, low_r};
        end
    end
endmodule

// [rtl/acw_cal_seq.sv]
module acw_cal_seq
    import acw_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Request
    input  wire logic          start,
    input  wire logic          kind,
    input  wire logic [1:0]    sel,
    // Analog calibration steps
    output logic               step_start,
    output acw_cal_step_t      step,
    input  wire logic          step_done,
    // Progress
    output logic               busy,
    output logic               done
);
    acw_seq_state_t state_r;
    logic           kind_r;
    logic [1:0]     sel_r;
    logic [1:0]     idx_r;
    logic [1:0]     last_idx;

    function automatic acw_cal_step_t step_of(input logic k, input logic [1:0] s,
                                               input logic [1:0] i);
        acw_cal_step_t g;
        acw_cal_step_t o;
        g = k ? CAL_STEP_SYS_GAIN : CAL_STEP_INT_GAIN;
        o = k ? CAL_STEP_SYS_OFS : CAL_STEP_INT_OFS;
        if (s == CSEL_FULL)
            step_of = (i == 2'd0) ? CAL_STEP_DAC : ((i == 2'd1) ? g : o);
        else if (s == CSEL_GAIN_OFS)
            step_of = (i == 2'd0) ? g : o;
        else if (s == CSEL_OFS)
            step_of = o;
        else
            step_of = g;
    endfunction

    assign last_idx = (sel_r == CSEL_FULL) ? 2'd2 : ((sel_r == CSEL_GAIN_OFS) ? 2'd1 : 2'd0);
    assign busy     = (state_r != SEQ_IDLE);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_r    <= SEQ_IDLE;
            kind_r     <= 1'b0;
            sel_r      <= CSEL_FULL;
            idx_r      <= 2'd0;
            step_start <= 1'b0;
            step       <= CAL_STEP_DAC;
            done       <= 1'b0;
        end
        else
        begin
            step_start <= 1'b0;
            done       <= 1'b0;
            case (state_r)
                SEQ_IDLE:
                    if (start)
                    begin
                        kind_r  <= kind;
                        sel_r   <= sel;
                        idx_r   <= 2'd0;
                        state_r <= SEQ_ISSUE;
                    end
                SEQ_ISSUE:
                begin
                    step_start <= 1'b1;
                    step       <= step_of(kind_r, sel_r, idx_r);
                    state_r    <= SEQ_WAIT;
                end
                SEQ_WAIT:
                    if (step_done)
                    begin
                        if (idx_r == last_idx)
                        begin
                            done    <= 1'b1;
                            state_r <= SEQ_IDLE;
                        end
                        else
                        begin
                            idx_r   <= idx_r + 2'd1;
                            state_r <= SEQ_ISSUE;
                        end
                    end
                default:
                    state_r <= SEQ_IDLE;
            endcase
        end
    end
endmodule

// [rtl/acw_decoder.sv]
// Behaviour
// R1 - Control word is 14-bit, write only
// R2 - Control write only with address 11
// R3 - Power-up clears every control bit
// R4 - Host writes zeros into bits 13..10
// R5 - Bits 9..8 pick power-down mode
// R6 - Bits 7..6 pick read source
// R7 - Range bit 0: unipolar, straight binary
// R8 - Range bit 1: bipolar, twos complement
// R9 - Conversion launch bit starts one conversion
// R10 - Conversion launch bit self-clears when done
// R11 - Bit 3: self or system calibration
// R12 - With launch, select bits pick calibration
// R13 - Calibration launch bit self-clears when done
// R14 - Without launch, select bits target coefficients
// R15 - Self 00: DAC, gain, offset
// R16 - Self 01 gain+offset, 10 offset, 11 gain
// R17 - System 00: DAC, gain, offset
// R18 - System 01 gain+offset, 10 offset, 11 gain
// R19 - Word arrives low byte then high
// R20 - Read codes: result, test, cal, status
// R21 - Result reads carry four leading zeros
// R22 - Status bit 4 shows busy
// R23 - Reserved upper bits have no effect
module acw_decoder
    import acw_pkg::*;
#(
    parameter int RESULT_WIDTH = 12
)
(
    // Clock and reset
    input  wire logic                   CLOCK,
    input  wire logic                   RST,
    // Host parallel port
    input  wire logic                   CS_N,
    input  wire logic                   WR_N,
    input  wire logic                   RD_N,
    input  wire logic                   HIGH_BYTE_SEL,
    input  wire logic [7:0]             DB_IN,
    output logic [7:0]                  DB_OUT,
    output logic                        DB_OE,
    // Conversion core
    input  wire logic [RESULT_WIDTH-1:0] RESULT_RAW,
    input  wire logic                   CONV_DONE,
    output logic                        CONV_START,
    // Calibration core
    output logic                        CAL_STEP_START,
    output acw_pkg::acw_cal_step_t      CAL_STEP,
    input  wire logic                   CAL_STEP_DONE,
    output logic                        CAL_WRITE_STB,
    output logic [13:0]                 CAL_WRITE_DATA,
    output logic                        CAL_POINTER_RESET,
    input  wire logic [15:0]            CAL_READ_DATA,
    output logic                        CAL_READ_ADVANCE,
    // Mode outputs
    output logic [1:0]                  POWER_MGMT,
    output logic                        BIPOLAR_RANGE,
    output logic                        CAL_KIND,
    output logic [1:0]                  CAL_SELECT,
    output logic [1:0]                  READ_SELECT,
    output logic                        BUSY
);
    generate
        if (RESULT_WIDTH < 2 || RESULT_WIDTH > CW_WIDTH)
        begin : g_bad_width
            $error("RESULT_WIDTH must be 2..14");
        end
    endgenerate

    localparam int NPIN = 12;

    logic [NPIN-1:0]       pin_meta_r;
    logic [NPIN-1:0]       pin_sync_r;
    logic [NPIN-1:0]       pins_raw;
    logic                  cs_n_s;
    logic                  wr_n_s;
    logic                  rd_n_s;
    logic                  hbs_s;
    logic [7:0]            db_s;
    logic                  wr_n_d_r;
    logic                  rd_n_d_r;
    logic                  cs_n_d_r;
    logic                  byte_wr;
    logic                  rd_end;
    logic                  word_stb;
    logic [WORD_WIDTH-1:0] word;
    logic [1:0]            word_addr;
    logic                  ctrl_wr;
    logic [CW_WIDTH-1:0]   cw_r;
    logic [CW_WIDTH-1:0]   cw_in;
    logic [CW_WIDTH-1:0]   test_r;
    logic                  conv_busy;
    logic                  seq_busy;
    logic                  seq_done;
    logic                  seq_start_r;
    logic [RESULT_WIDTH-1:0] result_coded;
    logic [WORD_WIDTH-1:0] status_word;
    logic [WORD_WIDTH-1:0] rd_word;
    logic [WORD_WIDTH-1:0] rd_word_r;

    // Two-flop synchronisers for every pin input
    assign pins_raw = {CS_N, WR_N, RD_N, HIGH_BYTE_SEL, DB_IN};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge CLOCK or posedge RST)
            begin
                if (RST)
                begin
                    pin_meta_r[gi] <= 1'b1;
                    pin_sync_r[gi] <= 1'b1;
                end
                else
                begin
                    pin_meta_r[gi] <= pins_raw[gi];
                    pin_sync_r[gi] <= pin_meta_r[gi];
                end
            end
        end
    endgenerate

    assign cs_n_s = pin_sync_r[11];
    assign wr_n_s = pin_sync_r[10];
    assign rd_n_s = pin_sync_r[9];
    assign hbs_s  = pin_sync_r[8];
    assign db_s   = pin_sync_r[7:0];

    // Strobe edge detection
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            wr_n_d_r <= 1'b1;
            rd_n_d_r <= 1'b1;
            cs_n_d_r <= 1'b1;
        end
        else
        begin
            wr_n_d_r <= wr_n_s;
            rd_n_d_r <= rd_n_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // Strobe rising edge; select as it stood while the strobe was low
    assign byte_wr = wr_n_s & ~wr_n_d_r & ~cs_n_d_r;
    assign rd_end  = rd_n_s & ~rd_n_d_r & ~cs_n_d_r;

    acw_byte_pair u_pair
    (
        .clk      (CLOCK),
        .rst      (RST),
        .byte_stb (byte_wr),
        .byte_in  (db_s),
        .word_stb (word_stb),
        .word     (word)
    ); // [R19]

    assign word_addr = word[POS_ADDR_HI:POS_ADDR_LO];
    assign ctrl_wr   = word_stb && (word_addr == ADDR_CTRL); // [R2]
    assign cw_in     = word[CW_WIDTH-1:0] & CW_LIVE_MASK; // [R23] [R4]

    // Control word; launch bits clear themselves, a new launch wins
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            cw_r <= CW_RESET; // [R3]
        else if (ctrl_wr)
            cw_r <= cw_in; // [R1]
        else
        begin
            if (CONV_DONE)
                cw_r[POS_CONV_LAUNCH] <= 1'b0; // [R10]
            if (seq_done)
                cw_r[POS_CAL_LAUNCH] <= 1'b0; // [R13]
        end
    end

    // Conversion launch pulse
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            CONV_START <= 1'b0;
        else
            CONV_START <= ctrl_wr & cw_in[POS_CONV_LAUNCH]; // [R9]
    end

    assign conv_busy = cw_r[POS_CONV_LAUNCH];

    // Calibration launch request
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            seq_start_r <= 1'b0;
        else
            seq_start_r <= ctrl_wr & cw_in[POS_CAL_LAUNCH]; // [R12]
    end

    acw_cal_seq u_seq
    (
        .clk        (CLOCK),
        .rst        (RST),
        .start      (seq_start_r),
        .kind       (cw_r[POS_CAL_KIND]),
        .sel        (cw_r[POS_CAL_SEL_HI:POS_CAL_SEL_LO]),
        .step_start (CAL_STEP_START),
        .step       (CAL_STEP),
        .step_done  (CAL_STEP_DONE),
        .busy       (seq_busy),
        .done       (seq_done)
    ); // [R11] [R15] [R16] [R17] [R18]

    // Test register and calibration coefficient writes
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            test_r <= '0;
        else if (word_stb && word_addr == ADDR_TEST)
            test_r <= word[CW_WIDTH-1:0];
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            CAL_WRITE_STB     <= 1'b0;
            CAL_WRITE_DATA    <= '0;
            CAL_POINTER_RESET <= 1'b0;
            CAL_READ_ADVANCE  <= 1'b0;
        end
        else
        begin
            CAL_WRITE_STB     <= word_stb && word_addr == ADDR_CAL;
            CAL_POINTER_RESET <= ctrl_wr;
            CAL_READ_ADVANCE  <= rd_end & hbs_s & (cw_r[POS_RD_SEL_HI:POS_RD_SEL_LO] == RD_CAL);
            if (word_stb && word_addr == ADDR_CAL)
                CAL_WRITE_DATA <= word[CW_WIDTH-1:0];
        end
    end

    // Mode outputs registered from the control word; BUSY also takes the sequencer busy
    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
        begin
            POWER_MGMT    <= 2'h0;
            BIPOLAR_RANGE <= 1'b0;
            CAL_KIND      <= 1'b0;
            CAL_SELECT    <= CSEL_FULL;
            READ_SELECT   <= RD_RESULT;
            BUSY          <= 1'b0;
        end
        else
        begin
            POWER_MGMT    <= cw_r[POS_PM_HI:POS_PM_LO]; // [R5]
            BIPOLAR_RANGE <= cw_r[POS_RANGE];
            CAL_KIND      <= cw_r[POS_CAL_KIND]; // [R11]
            CAL_SELECT    <= cw_r[POS_CAL_SEL_HI:POS_CAL_SEL_LO]; // [R14]
            READ_SELECT   <= cw_r[POS_RD_SEL_HI:POS_RD_SEL_LO]; // [R6]
            BUSY          <= conv_busy | seq_busy; // [R22]
        end
    end

    // Offset binary from the core; flipping the MSB gives twos complement
    assign result_coded = cw_r[POS_RANGE]
                        ? {~RESULT_RAW[RESULT_WIDTH-1], RESULT_RAW[RESULT_WIDTH-2:0]} // [R8]
                        : RESULT_RAW; // [R7]

    assign status_word = {STATUS_ZEROS,
                          cw_r[POS_PM_HI:POS_PM_LO],
                          STATUS_ONES,
                          cw_r[POS_RANGE],
                          conv_busy | seq_busy, // [R22]
                          cw_r[POS_CAL_KIND],
                          cw_r[POS_CAL_SEL_HI:POS_CAL_SEL_LO],
                          seq_busy};

    // Read source; the control word itself is never a source
    always_comb
    begin
        rd_word = '0;
        if (cw_r[POS_RD_SEL_HI:POS_RD_SEL_LO] == RD_RESULT)
            rd_word = {{(WORD_WIDTH-RESULT_WIDTH){1'b0}}, result_coded}; // [R21] [R20]
        else if (cw_r[POS_RD_SEL_HI:POS_RD_SEL_LO] == RD_TEST)
            rd_word = {2'h0, test_r}; // [R20]
        else if (cw_r[POS_RD_SEL_HI:POS_RD_SEL_LO] == RD_CAL)
            rd_word = CAL_READ_DATA; // [R20]
        else
            rd_word = status_word; // [R20] [R1]
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            rd_word_r <= '0;
        else
            rd_word_r <= rd_word; // [R6]
    end

    always_ff @(posedge CLOCK or posedge RST)
    begin
        if (RST)
            DB_OUT <= 8'h00;
        else
            DB_OUT <= hbs_s ? rd_word_r[15:8] : rd_word_r[7:0];
    end

    assign DB_OE = ~cs_n_s & ~rd_n_s;
endmodule

// [verification/acw_decoder_properties.sv]
module acw_decoder_properties
    import acw_pkg::*;
(
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RST,
    // Host port
    input wire logic       CS_N,
    input wire logic       RD_N,
    input wire logic       DB_OE,
    // Cores
    input wire logic       CONV_START,
    input wire logic       CAL_STEP_START,
    input wire logic       CAL_STEP_DONE,
    input wire logic       CAL_POINTER_RESET,
    // Modes
    input wire logic [1:0] POWER_MGMT,
    input wire logic [1:0] READ_SELECT,
    input wire logic       BIPOLAR_RANGE,
    input wire logic       BUSY
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    conv_pulse_a: assert property (CONV_START |=> !CONV_START)
        else $error("conversion launch longer than one cycle");
    conv_busy_a: assert property (CONV_START |=> BUSY)
        else $error("busy missing after conversion launch");
    step_pulse_a: assert property (CAL_STEP_START |=> !CAL_STEP_START)
        else $error("calibration step launch longer than one cycle");
    step_busy_a: assert property (CAL_STEP_START |-> BUSY)
        else $error("busy missing during calibration");
    step_next_a: assert property (CAL_STEP_DONE |-> ##2 (CAL_STEP_START || !BUSY))
        else $error("no next step and no end after step done");
    oe_track_a: assert property (DB_OE |-> (!$past(RD_N, 2) && !$past(CS_N, 2)) || !$past(RD_N, 3))
        else $error("read drive without a read strobe");
    oe_idle_a: assert property (RD_N [*4] |-> !DB_OE)
        else $error("read drive while no read");
    mode_write_a: assert property (
        $changed(READ_SELECT) || $changed(POWER_MGMT) || $changed(BIPOLAR_RANGE)
        |-> $past(CAL_POINTER_RESET) || $past(CAL_POINTER_RESET, 2))
        else $error("mode change without a control write");
endmodule

// [verification/acw_host_model.sv]
module acw_host_model
(
    // Clock
    input wire logic       clk,
    // Parallel port
    output logic           cs_n,
    output logic           wr_n,
    output logic           rd_n,
    output logic           hbs,
    output logic [7:0]     db,
    input wire logic [7:0] db_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cs_n = 1'b1;
        wr_n = 1'b1;
        rd_n = 1'b1;
        hbs  = 1'b0;
        db   = 8'h5A;
    end

    task automatic put_byte(input logic [7:0] b);
        @(negedge clk);
        cs_n = 1'b0;
        db   = b;
        wr_n = 1'b0;
        repeat (3) @(negedge clk);
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        // Released bus must not keep the last value
        db   = ~b;
    endtask

    task automatic write_word(input logic [15:0] w);
        put_byte(w[7:0]);
        put_byte(w[15:8]);
        repeat (4) @(negedge clk);
    endtask

    task automatic read_byte(input logic hi, output logic [7:0] d);
        @(negedge clk);
        hbs  = hi;
        cs_n = 1'b0;
        rd_n = 1'b0;
        repeat (6) @(negedge clk);
        d    = db_out;
        rd_n = 1'b1;
        cs_n = 1'b1;
        repeat (4) @(negedge clk);
    endtask
endmodule

// [verification/test_adc_control_word_decoder.sv]
module test_adc_control_word_decoder;
    import acw_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] RAW = 12'hA53;
    localparam logic [15:0] CAL_RD = 16'h2C71;
    logic                   CLOCK, RST, CS_N, WR_N, RD_N, HIGH_BYTE_SEL, DB_OE;
    logic [7:0]             DB_IN, DB_OUT;
    logic                   CONV_DONE = 1'b0;
    logic                   CAL_STEP_DONE = 1'b0;
    logic                   CONV_START, CAL_STEP_START, BIPOLAR_RANGE, CAL_KIND, BUSY;
    acw_cal_step_t          CAL_STEP;
    logic [1:0]             POWER_MGMT, CAL_SELECT, READ_SELECT;
    logic [13:0]            CAL_WRITE_DATA;
    logic                   CAL_READ_ADVANCE;
    int                     n_adv = 0;
    int                     n_fail = 0;
    int                     n_compared = 0;
    int                     cycles = 0;
    int                     conv_cnt = 0;
    int                     step_cnt = 0;
    int                     n_conv = 0;
    acw_cal_step_t          steps[$];

    acw_decoder i_acw_decoder (
        .CLOCK, .RST, .CS_N, .WR_N, .RD_N, .HIGH_BYTE_SEL, .DB_IN, .DB_OUT, .DB_OE,
        .RESULT_RAW(RAW), .CONV_DONE, .CONV_START, .CAL_STEP_START, .CAL_STEP, .CAL_STEP_DONE,
        .CAL_WRITE_STB(), .CAL_WRITE_DATA, .CAL_POINTER_RESET(), .CAL_READ_DATA(CAL_RD),
        .CAL_READ_ADVANCE, .POWER_MGMT, .BIPOLAR_RANGE, .CAL_KIND, .CAL_SELECT, .READ_SELECT, .BUSY
    );

    acw_host_model i_acw_host_model (
        .clk(CLOCK), .cs_n(CS_N), .wr_n(WR_N), .rd_n(RD_N), .hbs(HIGH_BYTE_SEL), .db(DB_IN), .db_out(DB_OUT)
    );

    initial
    begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end

    // Converter and calibration core stand-in, plus hang guard
    always @(negedge CLOCK)
    begin
        CONV_DONE <= (conv_cnt == 1);
        CAL_STEP_DONE <= (step_cnt == 1);
        conv_cnt <= CONV_START ? 40 : (conv_cnt > 0 ? conv_cnt - 1 : 0);
        step_cnt <= CAL_STEP_START ? 5 : (step_cnt > 0 ? step_cnt - 1 : 0);
        if (CONV_START)
            n_conv <= n_conv + 1;
        if (CAL_READ_ADVANCE)
            n_adv <= n_adv + 1;
        if (CAL_STEP_START)
            steps.push_back(CAL_STEP);
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            n_fail++;
            final_report();
        end
    end

    task automatic final_report();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    function automatic logic [15:0] cw(input logic [1:0] pm, rs, input logic rng, cv, ck,
                                        input logic [1:0] cs, input logic cl);
        return {ADDR_CTRL, 4'h0, pm, rs, rng, cv, ck, cs, cl};
    endfunction

    function automatic logic [15:0] modes();
        return {7'h00, POWER_MGMT, READ_SELECT, BIPOLAR_RANGE, CAL_KIND, CAL_SELECT, BUSY};
    endfunction

    task automatic wr(input logic [15:0] w);
        i_acw_host_model.write_word(w);
    endtask

    task automatic rd(output logic [15:0] w);
        i_acw_host_model.read_byte(1'b0, w[7:0]);
        i_acw_host_model.read_byte(1'b1, w[15:8]);
    endtask

    task automatic wait_idle();
        repeat (4) @(negedge CLOCK);
        for (int i = 0; i < 400 && BUSY !== 1'b0; i++)
            @(negedge CLOCK);
    endtask

    task automatic t_result();
        logic [15:0] w;
        check(modes(), 16'h0000, "reset modes");
        rd(w);
        check(w, {4'h0, RAW}, "unipolar result");
        wr(cw(2'h0, RD_RESULT, 1'b1, 1'b0, 1'b0, CSEL_FULL, 1'b0));
        rd(w);
        check(w, {4'h0, ~RAW[11], RAW[10:0]}, "bipolar result");
    endtask

    task automatic t_modes();
        logic [15:0] w;
        logic [15:0] e;
        e = {7'h00, 2'h2, RD_STATUS, 1'b0, 1'b1, CSEL_GAIN_OFS, 1'b0};
        steps.delete();
        // Reserved upper bits set on purpose
        wr(cw(2'h2, RD_STATUS, 1'b0, 1'b0, 1'b1, CSEL_GAIN_OFS, 1'b0) | 16'h3C00);
        check(modes(), e, "mode outputs");
        check(16'(steps.size()), 16'h0000, "no calibration without launch");
        rd(w);
        check(w, {6'h00, 2'h2, 2'h3, 1'b0, 1'b0, 1'b1, CSEL_GAIN_OFS, 1'b0}, "status");
        wr(16'h3FFF);
        wr(16'h7FFF);
        check(modes(), e, "other addresses");
        wr(16'hA5C3);
        check({2'h0, CAL_WRITE_DATA}, 16'h25C3, "coefficient data");
        wr(cw(2'h2, RD_TEST, 1'b0, 1'b0, 1'b1, CSEL_GAIN_OFS, 1'b0));
        rd(w);
        check(w, 16'h3FFF, "test readback");
        wr(cw(2'h2, RD_CAL, 1'b0, 1'b0, 1'b1, CSEL_GAIN_OFS, 1'b0));
        rd(w);
        check(w, CAL_RD, "coefficient readback");
        check(16'(n_adv), 16'h0001, "coefficient pointer step");
    endtask

    task automatic t_conv();
        logic [15:0] w;
        n_conv = 0;
        wr(cw(2'h0, RD_STATUS, 1'b0, 1'b1, 1'b0, CSEL_FULL, 1'b0));
        rd(w);
        check(w, 16'h00D0, "status while converting");
        wait_idle();
        check(16'(n_conv), 16'h0001, "conversion count");
        rd(w);
        check(w, 16'h00C0, "status after conversion");
    endtask

    task automatic t_cal();
        logic [15:0]   w;
        acw_cal_step_t g;
        acw_cal_step_t o;
        acw_cal_step_t e[$];
        for (int k = 0; k < 8; k++)
        begin
            g = k[2] ? CAL_STEP_SYS_GAIN : CAL_STEP_INT_GAIN;
            o = k[2] ? CAL_STEP_SYS_OFS : CAL_STEP_INT_OFS;
            case (k[1:0])
                2'h0: e = '{CAL_STEP_DAC, g, o};
                2'h1: e = '{g, o};
                2'h2: e = '{o};
                default: e = '{g};
            endcase
            steps.delete();
            wr(cw(2'h0, RD_STATUS, 1'b0, 1'b0, k[2], k[1:0], 1'b1));
            wait_idle();
            check(16'(steps.size()), 16'(e.size()), "step count");
            foreach (e[i])
                check(16'(steps[i]), 16'(e[i]), "calibration step");
            rd(w);
            check(w, {6'h00, 2'h0, 2'h3, 2'b00, k[2], k[1:0], 1'b0}, "status after calibration");
        end
    endtask

    initial
    begin
        RST = 1'b1;
        repeat (2) @(negedge CLOCK);
        RST = 1'b0;
        repeat (3) @(negedge CLOCK);
        t_result();
        t_modes();
        t_conv();
        t_cal();
        final_report();
    end
endmodule

bind acw_decoder acw_decoder_properties i_acw_decoder_properties (
    .CLOCK, .RST, .CS_N, .RD_N, .DB_OE, .CONV_START, .CAL_STEP_START, .CAL_STEP_DONE,
    .CAL_POINTER_RESET, .POWER_MGMT, .READ_SELECT, .BIPOLAR_RANGE, .BUSY
);
